// ---- kms_pkg.sv ----
package kms_pkg;

    // --------------------------------------------------------
    // Geometry
    // --------------------------------------------------------
    localparam int ROWS = 18;
    localparam int COLS = 8;

    // --------------------------------------------------------
    // Address map
    // --------------------------------------------------------
    localparam logic [31:0] BASE_ADDR  = 32'h4000_9c00;
    localparam logic [7:0]  OFS_ROWSEL = 8'h04;
    localparam logic [7:0]  OFS_LEVEL  = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0c;
    localparam logic [7:0]  OFS_IRQEN  = 8'h10;
    localparam logic [7:0]  OFS_EXTCTL = 8'h14;

    // --------------------------------------------------------
    // Fields of row_output_select and extended control
    // --------------------------------------------------------
    localparam int SEL_LSB  = 0;
    localparam int ALL_BIT  = 5;
    localparam int DIS_BIT  = 6;
    localparam int POL_BIT  = 7;
    localparam int PRED_BIT = 0;

    // --------------------------------------------------------
    // Reset values
    // --------------------------------------------------------
    localparam logic [4:0] RST_SEL  = 5'h00;
    localparam logic       RST_ALL  = 1'h0;
    localparam logic       RST_DIS  = 1'h1;
    localparam logic       RST_POL  = 1'h0;
    localparam logic       RST_PRED = 1'h0;

    // --------------------------------------------------------
    // Timing
    // --------------------------------------------------------
    localparam int CLK_MHZ    = 200;
    localparam int PREDRV_NS  = 100;
    localparam int PREDRV_CYC = (PREDRV_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        PD_IDLE  = 2'b01,
        PD_DRIVE = 2'b10
    } kms_pd_e;

endpackage

// ---- kms_scan.sv ----
module kms_scan
    import kms_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_ack,
    input  wire logic [COLS-1:0]   column_sense_in,
    output logic      [ROWS-1:0]   row_drive_out,
    output logic      [ROWS-1:0]   row_drive_oe,
    input  wire logic              bus_clk_stopped,
    output logic                   scan_irq,
    output logic                   scan_wake_irq,
    output logic                   clock_request2_status,
    output logic                   sleep_block
);

    // --------------------------------------------------------
    // Register state
    // --------------------------------------------------------
    logic [4:0]        row_select_r;
    logic              row_drive_all_r;
    logic              scan_disable_r;
    logic              row_polarity_r;
    logic              predrive_enable_r;
    logic [COLS-1:0]   status_r;
    logic [COLS-1:0]   status_nxt;
    logic [COLS-1:0]   irq_en_r;

    // --------------------------------------------------------
    // Address decode
    // --------------------------------------------------------
    wire        in_block  = reg_addr[31:8] == BASE_ADDR[31:8];
    wire [7:0]  ofs       = reg_addr[7:0];
    wire        hit_sel   = in_block && ofs == OFS_ROWSEL;
    wire        hit_lvl   = in_block && ofs == OFS_LEVEL;
    wire        hit_sts   = in_block && ofs == OFS_STATUS;
    wire        hit_en    = in_block && ofs == OFS_IRQEN;
    wire        hit_ext   = in_block && ofs == OFS_EXTCTL;
    wire        wr_sel    = reg_wr && hit_sel;
    wire        wr_sts    = reg_wr && hit_sts;
    wire        wr_en     = reg_wr && hit_en;
    wire        wr_ext    = reg_wr && hit_ext;

    // --------------------------------------------------------
    // Column synchroniser and edge detect
    // --------------------------------------------------------
    logic [COLS-1:0] col_meta_r;
    logic [COLS-1:0] col_sync_r;
    logic [COLS-1:0] col_prev_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            col_meta_r <= '1;
            col_sync_r <= '1;
            col_prev_r <= '1;
        end else begin
            col_meta_r <= column_sense_in;
            col_sync_r <= col_meta_r;
            col_prev_r <= col_sync_r;
        end
    end

    // One pulse per falling edge, taken from settled stages only
    wire [COLS-1:0] col_fall  = col_prev_r & ~col_sync_r;
    wire            cols_high = &col_sync_r;

    // --------------------------------------------------------
    // Edge status, set wins over a same-cycle clear
    // --------------------------------------------------------
    wire [COLS-1:0] clr_mask = wr_sts ? reg_wdata[COLS-1:0] : '0;

    assign status_nxt = (status_r & ~clr_mask) | col_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    // --------------------------------------------------------
    // Control registers
    // --------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            row_select_r      <= RST_SEL;
            row_drive_all_r   <= RST_ALL;
            scan_disable_r    <= RST_DIS;
            row_polarity_r    <= RST_POL;
            predrive_enable_r <= RST_PRED;
            irq_en_r          <= '0;
        end else begin
            if (wr_sel) begin
                row_select_r    <= reg_wdata[SEL_LSB+:5];
                row_drive_all_r <= reg_wdata[ALL_BIT];
                scan_disable_r  <= reg_wdata[DIS_BIT];
                row_polarity_r  <= reg_wdata[POL_BIT];
            end
            if (wr_en) begin
                irq_en_r <= reg_wdata[COLS-1:0];
            end
            if (wr_ext) begin
                predrive_enable_r <= reg_wdata[PRED_BIT];
            end
        end
    end

    // --------------------------------------------------------
    // Row drive levels
    // --------------------------------------------------------
    logic [ROWS-1:0] row_onehot;
    logic [ROWS-1:0] row_level;

    always_comb begin
        row_onehot = '0;
        for (int i = 0; i < ROWS; i++) begin
            row_onehot[i] = !row_drive_all_r && row_select_r == 5'(i);
        end
    end

    // Out-of-range selects leave every row at the idle level
    assign row_level = row_polarity_r ? row_onehot : ~row_onehot;

    // --------------------------------------------------------
    // Predrive: rows going high are pushed high for a while
    // --------------------------------------------------------
    localparam int PW = $clog2(PREDRV_CYC + 1);

    kms_pd_e         pd_state_r;
    kms_pd_e         pd_state_nxt;
    logic [PW-1:0]   pd_cnt_r;
    logic [PW-1:0]   pd_cnt_nxt;
    logic [ROWS-1:0] pd_mask_r;
    logic [ROWS-1:0] pd_mask_nxt;
    logic [ROWS-1:0] level_prev_r;

    wire [ROWS-1:0] row_rise  = row_level & ~level_prev_r;
    wire            pd_launch = predrive_enable_r && !scan_disable_r
                                && |row_rise;

    always_comb begin
        pd_state_nxt = pd_state_r;
        pd_cnt_nxt   = pd_cnt_r;
        pd_mask_nxt  = pd_mask_r;
        case (pd_state_r)
            PD_IDLE: begin
                pd_mask_nxt = '0;
                if (pd_launch) begin
                    pd_state_nxt = PD_DRIVE;
                    pd_cnt_nxt   = PW'(PREDRV_CYC - 1);
                    pd_mask_nxt  = row_rise;
                end
            end
            PD_DRIVE: begin
                // A fresh rise restarts the window so it is not cut short
                if (pd_launch) begin
                    pd_cnt_nxt  = PW'(PREDRV_CYC - 1);
                    pd_mask_nxt = (pd_mask_r & row_level) | row_rise;
                end else if (pd_cnt_r == '0 || scan_disable_r) begin
                    pd_state_nxt = PD_IDLE;
                    pd_mask_nxt  = '0;
                end else begin
                    pd_cnt_nxt  = pd_cnt_r - 1'b1;
                    pd_mask_nxt = pd_mask_r & row_level;
                end
            end
            default: begin
                pd_state_nxt = PD_IDLE;
                pd_cnt_nxt   = '0;
                pd_mask_nxt  = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pd_state_r   <= PD_IDLE;
            pd_cnt_r     <= '0;
            pd_mask_r    <= '0;
            level_prev_r <= '1;
        end else begin
            pd_state_r   <= pd_state_nxt;
            pd_cnt_r     <= pd_cnt_nxt;
            pd_mask_r    <= pd_mask_nxt;
            level_prev_r <= row_level;
        end
    end

    // --------------------------------------------------------
    // Pad drive: low is driven, high floats unless predriven
    // --------------------------------------------------------
    logic [ROWS-1:0] row_out_r;
    logic [ROWS-1:0] row_oe_r;

    wire [ROWS-1:0] oe_nxt = scan_disable_r ? '0
                           : (~row_level | pd_mask_nxt);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            row_out_r <= '1;
            row_oe_r  <= '0;
        end else begin
            row_out_r <= row_level;
            row_oe_r  <= oe_nxt;
        end
    end

    assign row_drive_out = row_out_r;
    assign row_drive_oe  = row_oe_r;

    // --------------------------------------------------------
    // Runtime interrupt with re-arm
    // --------------------------------------------------------
    logic            scan_irq_r;
    logic            irq_block_r;
    logic [COLS-1:0] qual_prev_r;

    wire [COLS-1:0] qual     = status_nxt & irq_en_r;
    wire            pending  = |qual;
    // Re-arm once all keys are up or the qualifying set moves
    wire            rearm    = cols_high || qual != qual_prev_r;
    wire            irq_nxt  = pending && !bus_clk_stopped
                               && !(irq_block_r && !rearm);
    wire            block_nxt = (scan_irq_r && !irq_nxt) ? 1'b1
                              : (rearm ? 1'b0 : irq_block_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scan_irq_r  <= 1'b0;
            irq_block_r <= 1'b0;
            qual_prev_r <= '0;
        end else begin
            scan_irq_r  <= irq_nxt;
            irq_block_r <= block_nxt;
            qual_prev_r <= qual;
        end
    end

    assign scan_irq = scan_irq_r;

    // --------------------------------------------------------
    // Wake request while the bus clock is stopped
    // --------------------------------------------------------
    logic wake_r;

    wire wake_set = bus_clk_stopped && |(col_fall & irq_en_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_set || (wake_r && bus_clk_stopped);
        end
    end

    assign scan_wake_irq         = wake_r;
    assign clock_request2_status = wake_r;

    // --------------------------------------------------------
    // Sleep hold: scanning means enabled with one row selected
    // --------------------------------------------------------
    logic sleep_block_r;

    wire scanning = !scan_disable_r && |row_onehot;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sleep_block_r <= 1'b0;
        end else begin
            sleep_block_r <= scanning || pd_state_r == PD_DRIVE;
        end
    end

    assign sleep_block = sleep_block_r;

    // --------------------------------------------------------
    // Read path, one cycle behind the strobe
    // --------------------------------------------------------
    logic [31:0] rdata_r;
    logic        ack_r;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hit_sel) begin
            rd_mux[SEL_LSB+:5]  = row_select_r;
            rd_mux[ALL_BIT]     = row_drive_all_r;
            rd_mux[DIS_BIT]     = scan_disable_r;
            rd_mux[POL_BIT]     = row_polarity_r;
        end else if (hit_lvl) begin
            rd_mux[COLS-1:0]    = col_sync_r;
        end else if (hit_sts) begin
            rd_mux[COLS-1:0]    = status_r;
        end else if (hit_en) begin
            rd_mux[COLS-1:0]    = irq_en_r;
        end else if (hit_ext) begin
            rd_mux[PRED_BIT]    = predrive_enable_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
            ack_r   <= 1'b0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : '0;
            ack_r   <= reg_rd || reg_wr;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_ack   = ack_r;

endmodule

// ---- kms_scan_chk.sv ----
module kms_scan_chk
    import kms_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            rst,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [31:0]     reg_addr,
    input wire logic [31:0]     reg_wdata,
    input wire logic [31:0]     reg_rdata,
    input wire logic            reg_ack,
    input wire logic [COLS-1:0] column_sense_in,
    input wire logic [ROWS-1:0] row_drive_out,
    input wire logic [ROWS-1:0] row_drive_oe,
    input wire logic            bus_clk_stopped,
    input wire logic            scan_irq,
    input wire logic            scan_wake_irq,
    input wire logic            clock_request2_status,
    input wire logic            sleep_block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]      ctl_r;
    logic [7:0]      en_r;
    logic            pd_r;
    logic [7:0]      hi_r;
    logic [ROWS-1:0] one_w;
    logic [ROWS-1:0] lvl_w;
    logic [31:0]     at_w;
    logic            hi_w;
    logic            acc_w;
    assign at_w  = reg_wr ? reg_addr - BASE_ADDR : 32'hffff_ffff;
    assign one_w = ROWS'(1) << ctl_r[4:0];
    assign lvl_w = (ctl_r[5] || ctl_r[4:0] >= 5'(ROWS)) ? {ROWS{~ctl_r[7]}} :
                   ctl_r[7] ? one_w : ~one_w;
    // Predrive length is measured on row 0 only
    assign hi_w  = row_drive_oe[0] && row_drive_out[0];
    assign acc_w = reg_wr || reg_rd;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_r <= 8'h40;
            en_r  <= 8'h00;
            pd_r  <= 1'h0;
            hi_r  <= 8'h00;
        end else begin
            ctl_r <= at_w == 32'(OFS_ROWSEL) ? reg_wdata[7:0] : ctl_r;
            en_r  <= at_w == 32'(OFS_IRQEN) ? reg_wdata[7:0] : en_r;
            pd_r  <= at_w == 32'(OFS_EXTCTL) ? reg_wdata[0] : pd_r;
            hi_r  <= hi_w ? hi_r + 8'h01 : 8'h00;
        end
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    rows_off_a: assert property (
        ctl_r[6] && $past(ctl_r[6]) |-> row_drive_oe == '0) else $error("rows on");
    row_level_a: assert property (
        !ctl_r[6] && !pd_r && $stable(ctl_r) && $stable(pd_r)
        |-> row_drive_out == lvl_w && row_drive_oe == ~lvl_w) else $error("row level");
    sleep_hold_a: assert property ($stable(ctl_r) |->
        sleep_block == (!ctl_r[6] && !ctl_r[5] && ctl_r[4:0] < 5'(ROWS))) else $error("sleep");
    irq_rise_a: assert property (
        !bus_clk_stopped && |(~column_sense_in & $past(column_sense_in) & en_r)
        |-> ##[1:5] scan_irq) else $error("irq late");
    irq_clear_a: assert property (
        at_w == 32'(OFS_IRQEN) && reg_wdata[7:0] == 8'h00 ||
        at_w == 32'(OFS_STATUS) && reg_wdata[7:0] == 8'hff |-> ##2 !scan_irq)
        else $error("irq stuck");
    wake_rise_a: assert property (
        bus_clk_stopped && |(~column_sense_in & $past(column_sense_in) & en_r)
        |-> ##[1:5] scan_wake_irq && clock_request2_status) else $error("no wake");
    wake_hold_a: assert property (
        scan_wake_irq && bus_clk_stopped |=> scan_wake_irq) else $error("wake lost");
    wake_drop_a: assert property (
        !bus_clk_stopped [*2] |-> !scan_wake_irq) else $error("wake stuck");
    sleep_irq_a: assert property (
        bus_clk_stopped [*2] |-> !scan_irq) else $error("irq in sleep");
    pred_time_a: assert property (
        $fell(hi_w) |-> hi_r == 8'(PREDRV_CYC)) else $error("predrive time");
    bus_ack_a: assert property (
        reg_ack == $past(acc_w)) else $error("ack");
    cover property ($rose(scan_irq));
    cover property ($rose(scan_wake_irq));
    cover property ($fell(hi_w));
endmodule

// ---- kms_matrix.sv ----
module kms_matrix
    import kms_pkg::*;
(
    input  wire logic [ROWS-1:0]           row_drive_out,
    input  wire logic [ROWS-1:0]           row_drive_oe,
    input  wire logic [ROWS-1:0][COLS-1:0] keys,
    output logic      [COLS-1:0]           column_sense_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ROWS-1:0] sink_w;
    // Only a row that sinks current can pull a closed key low
    assign sink_w = row_drive_oe & ~row_drive_out;
    always_comb begin
        column_sense_in = '1;
        for (int r = 0; r < ROWS; r++) begin
            if (sink_w[r]) begin
                column_sense_in &= ~keys[r];
            end
        end
    end
endmodule

// ---- keyboard_matrix_scan_bench.sv ----
module keyboard_matrix_scan_bench
    import kms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      clk_sys;
    logic                      rst;
    logic                      reg_wr;
    logic                      reg_rd;
    logic                      bus_clk_stopped;
    logic [31:0]               reg_addr;
    logic [31:0]               reg_wdata;
    logic [31:0]               reg_rdata;
    logic                      reg_ack;
    logic                      scan_irq;
    logic                      scan_wake_irq;
    logic                      clock_request2_status;
    logic                      sleep_block;
    logic [COLS-1:0]           column_sense_in;
    logic [ROWS-1:0]           row_drive_out;
    logic [ROWS-1:0]           row_drive_oe;
    logic [ROWS-1:0][COLS-1:0] keys;
    logic [31:0]               seed;
    logic [31:0]               rdv;
    logic [31:0]               d;
    logic [7:0]                ctl;
    logic [7:0]                en;
    int                        r;
    int                        failures;
    int                        total_checks;
    // Extended control comes before the row register, so predrive never moves while scanning
    logic [7:0] ofs_t [6] = '{8'h00, 8'h14, 8'h08, 8'h0c, 8'h10, 8'h04};
    logic [7:0] rst_t [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h40};
    logic [7:0] msk_t [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff};

    kms_scan dut_u (.*);
    kms_matrix mat_u (.*);

    initial clk_sys = 1'h0;
    always #2.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [ROWS-1:0] lvl(input logic [7:0] c);
        logic [ROWS-1:0] oh;
        oh = ROWS'(1) << c[4:0];
        if (c[5] || c[4:0] >= 5'(ROWS)) return {ROWS{~c[7]}};
        return c[7] ? oh : ~oh;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(negedge clk_sys);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = BASE_ADDR + 32'(ofs);
        reg_wdata = wd;
        @(negedge clk_sys);
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        rdv = reg_rdata;
        chk("ack", 32'h1, 32'(reg_ack));
    endtask

    task automatic waitn(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under 2000 cycles
    initial begin
        #50000;
        failures++;
        summarize();
    end

    initial begin
        {rst, reg_wr, reg_rd, bus_clk_stopped} = 4'h8;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        keys = '0;
        seed = 32'h8e70;
        failures = 0;
        total_checks = 0;
        waitn(6);
        rst = 1'h0;
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, ofs_t[i], 32'h0);
            chk("reset value", 32'(rst_t[i]), rdv);
        end
        for (int i = 0; i < 6; i++) begin
            d = rnd() & 32'hffff_fffe;
            bus(1'h1, ofs_t[i], d);
            bus(1'h0, ofs_t[i], 32'h0);
            chk("readback", (d & 32'(msk_t[i])) | (i == 2 ? 32'hff : 32'h0), rdv);
        end
        for (int i = 0; i < 40; i++) begin
            ctl = (i < 2) ? 8'h11 + 8'(i) : 8'(rnd());
            bus(1'h1, OFS_ROWSEL, 32'(ctl));
            waitn(2);
            if (!ctl[6]) begin
                chk("row level", {14'h0, lvl(ctl)}, 32'(row_drive_out));
            end
            d = ctl[6] ? 32'h0 : {14'h0, ~lvl(ctl)};
            chk("row enable", d, 32'(row_drive_oe));
            d = 32'(ctl[6:5] == 2'h0 && ctl[4:0] < 5'(ROWS));
            chk("sleep", d, 32'(sleep_block));
        end
        for (int c = 0; c < COLS; c++) begin
            r = int'(rnd() % ROWS);
            en = 8'(rnd());
            bus(1'h1, OFS_IRQEN, 32'(en));
            bus(1'h1, OFS_ROWSEL, 32'(r));
            waitn(2);
            // A second key on an idle row must stay invisible
            keys[r][c] = 1'h1;
            keys[(r + 1) % ROWS][(c + 1) % COLS] = 1'h1;
            waitn(6);
            bus(1'h0, OFS_LEVEL, 32'h0);
            chk("columns", {24'h0, ~(8'h01 << c)}, rdv);
            chk("irq", 32'(en[c]), 32'(scan_irq));
            bus(1'h1, OFS_STATUS, {24'h0, ~(8'h01 << c)});
            bus(1'h0, OFS_STATUS, 32'h0);
            chk("status", 32'h1 << c, rdv);
            bus(1'h1, OFS_STATUS, 32'hff);
            bus(1'h0, OFS_STATUS, 32'h0);
            chk("status clear", 32'h0, rdv);
            chk("irq clear", 32'h0, 32'(scan_irq));
            keys = '0;
            waitn(4);
        end
        bus(1'h1, OFS_IRQEN, 32'hff);
        bus(1'h1, OFS_ROWSEL, 32'h0);
        bus_clk_stopped = 1'h1;
        waitn(3);
        keys[0][3] = 1'h1;
        waitn(12);
        chk("wake", 32'h3, {30'h0, scan_wake_irq, clock_request2_status});
        chk("irq asleep", 32'h0, 32'(scan_irq));
        bus_clk_stopped = 1'h0;
        waitn(6);
        chk("wake off", 32'h0, 32'(scan_wake_irq));
        chk("irq awake", 32'h1, 32'(scan_irq));
        bus(1'h0, OFS_STATUS, 32'h0);
        chk("status asleep", 32'h8, rdv);
        // Sleeping with the key still held must not re-raise the irq on wake
        bus_clk_stopped = 1'h1;
        waitn(3);
        chk("irq asleep", 32'h0, 32'(scan_irq));
        bus_clk_stopped = 1'h0;
        waitn(4);
        chk("irq held off", 32'h0, 32'(scan_irq));
        keys = '0;
        waitn(5);
        chk("irq rearmed", 32'h1, 32'(scan_irq));
        bus(1'h1, OFS_IRQEN, 32'h0);
        bus(1'h1, OFS_STATUS, 32'hff);
        keys = '0;
        bus(1'h1, OFS_ROWSEL, 32'h40);
        bus(1'h1, OFS_EXTCTL, 32'h1);
        bus(1'h0, OFS_EXTCTL, 32'h0);
        chk("predrive bit", 32'h1, rdv);
        bus(1'h1, OFS_ROWSEL, 32'h0);
        waitn(4);
        bus(1'h1, OFS_ROWSEL, 32'h1);
        waitn(2);
        chk("predrive on", 32'h3, {30'h0, row_drive_oe[0], row_drive_out[0]});
        waitn(PREDRV_CYC + 2);
        chk("predrive off", 32'h0, 32'(row_drive_oe[0]));
        bus(1'h1, OFS_ROWSEL, 32'h41);
        bus(1'h1, OFS_EXTCTL, 32'h0);
        bus(1'h1, OFS_ROWSEL, 32'h1);
        summarize();
    end
endmodule

bind kms_scan kms_scan_chk chk_u (.*);
